// ### rtl/changeover_pkg.sv
package changeover_pkg;

	// system clock rate and input filter time
	localparam int CLOCK_MHZ = 50;
	localparam int DEBOUNCE_NS = 10000;
	localparam int DEBOUNCE_CYC = (DEBOUNCE_NS * CLOCK_MHZ + 999) / 1000;
	localparam int DEBOUNCE_W = $clog2(DEBOUNCE_CYC + 1);

	// output channels that carry an amplifier alarm
	localparam int FIRST_OUT_CH = 3;
	localparam int LAST_OUT_CH = 11;
	localparam int NUM_OUT_CH = LAST_OUT_CH - FIRST_OUT_CH + 1;

	// positions inside the filtered remote input vector
	localparam int IDX_FAILOVER = 0;
	localparam int IDX_TOGGLE = 1;
	localparam int IDX_RESET = 2;
	localparam int NUM_REMOTE = 3;

	typedef enum logic {
		fault_only_mode,
		fault_plus_alarm_mode
	} report_mode_t;

	typedef enum logic {
		main_input,
		spare_input
	} source_t;

	// active-low remote pins, high when open
	typedef struct packed {
		logic reset_n;
		logic source_toggle_n;
		logic failover_enable_n;
	} remote_in_t;

	// settings that come either from panel switches or from the network
	typedef struct packed {
		report_mode_t report_mode_switch;
		logic out_alarm_en;
	} settings_t;

	localparam remote_in_t REMOTE_IDLE = '{reset_n: 1'b1, source_toggle_n: 1'b1,
		failover_enable_n: 1'b1};
	localparam settings_t NET_SET_RESET = '{report_mode_switch: fault_only_mode,
		out_alarm_en: 1'b1};
	localparam source_t SOURCE_RESET = main_input;

endpackage : changeover_pkg

// ### rtl/changeover_remote_port.sv
// Contract
// - panel on switch_on_fault: low remote enable disables failover, high restores it
// - panel failover disabled: remote failover-enable input is ignored
// - every separate low on the toggle input held past the filter time flips the selected source once
// - main-selected output high from one cycle after main_input is selected, low during reset
// - spare-selected output high from one cycle after spare_input is selected, low during reset
// - fault-only mode: fault on main or spare drives the fault flag high
// - fault-plus-alarm mode: channel 3..11 or supply alarms also raise the flag
// - fault flag stays latched after recovery until an explicit error reset
// - low level on the remote reset input clears the latched fault state
// - isolated contact open normally, conducts on flag condition or when unpowered
// - output alarm indication off: only supply alarms count toward the flag
// - network settings apply only while control selection is remote
// - switching local to remote restores the last remote settings
// - active failover moves away from a faulty selected source automatically while the other source is not faulty
`timescale 1ns/1ps
`default_nettype none

module changeover_remote_port
	import changeover_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire remote_in_t remote_in,
	input wire logic panel_failover_on,
	input wire logic control_remote,
	input wire settings_t local_set,
	input wire logic net_wr,
	input wire settings_t net_set,
	input wire logic main_fault,
	input wire logic spare_fault,
	input wire logic [NUM_OUT_CH-1:0] chan_alarm,
	input wire logic psu_alarm,
	output logic main_sel_out,
	output logic spare_sel_out,
	output logic fault_flag_out,
	output logic isolated_fault_pos,
	output logic isolated_fault_neg,
	output logic failover_active
);

	logic [NUM_REMOTE-1:0] sync1_q;
	logic [NUM_REMOTE-1:0] sync2_q;
	logic [NUM_REMOTE-1:0] filt_q;
	logic toggle_prev_q;
	logic toggle_fall;
	source_t sel_q;
	source_t sel_d;
	logic auto_switch;
	settings_t remote_set_q;
	settings_t eff_set;
	logic main_seen_q;
	logic spare_seen_q;
	logic alarm_seen_q;
	logic alarm_now;
	logic flag_cond;

	always_ff @(posedge clock) begin
		if (srst) begin
			sync1_q <= REMOTE_IDLE;
			sync2_q <= REMOTE_IDLE;
		end else begin
			sync1_q <= remote_in;
			sync2_q <= sync1_q;
		end
	end

	// per-pin debounce
	// a level must hold for the whole window; short glitches never reach the logic
	for (genvar i = 0; i < NUM_REMOTE; i++) begin : g_filter
		logic [DEBOUNCE_W-1:0] cnt_q;
		always_ff @(posedge clock) begin
			if (srst) begin
				cnt_q <= '0;
				filt_q[i] <= 1'b1;
			end else if (sync2_q[i] == filt_q[i]) begin
				cnt_q <= '0;
			end else if (cnt_q == DEBOUNCE_W'(DEBOUNCE_CYC - 1)) begin
				cnt_q <= '0;
				filt_q[i] <= sync2_q[i];
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			toggle_prev_q <= 1'b1;
		end else begin
			toggle_prev_q <= filt_q[IDX_TOGGLE];
		end
	end

	assign toggle_fall = toggle_prev_q & ~filt_q[IDX_TOGGLE];

	always_ff @(posedge clock) begin
		if (srst) begin
			failover_active <= 1'b0;
		end else begin
			failover_active <= panel_failover_on & filt_q[IDX_FAILOVER];
		end
	end

	// leave a faulty source
	// no move when both sources fail; that would just swap one bad feed for another
	always_comb begin
		auto_switch = 1'b0;
		unique case (sel_q)
			main_input: auto_switch = failover_active & main_fault & ~spare_fault;
			spare_input: auto_switch = failover_active & spare_fault & ~main_fault;
		endcase
	end

	// automatic failover wins over a press landing in the same cycle
	always_comb begin
		sel_d = sel_q;
		if (auto_switch || toggle_fall) begin
			unique case (sel_q)
				main_input: sel_d = spare_input;
				spare_input: sel_d = main_input;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			sel_q <= SOURCE_RESET;
		end else begin
			sel_q <= sel_d;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			main_sel_out <= 1'b0;
			spare_sel_out <= 1'b0;
		end else begin
			main_sel_out <= (sel_q == main_input);
			spare_sel_out <= (sel_q == spare_input);
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			remote_set_q <= NET_SET_RESET;
		end else if (net_wr && control_remote) begin
			remote_set_q <= net_set;
		end
	end

	assign eff_set = control_remote ? remote_set_q : local_set;

	assign alarm_now = psu_alarm | (eff_set.out_alarm_en & (|chan_alarm));

	// reset input clears, a new event wins
	always_ff @(posedge clock) begin
		if (srst) begin
			main_seen_q <= 1'b0;
			spare_seen_q <= 1'b0;
			alarm_seen_q <= 1'b0;
		end else begin
			main_seen_q <= main_fault | (main_seen_q & filt_q[IDX_RESET]);
			spare_seen_q <= spare_fault | (spare_seen_q & filt_q[IDX_RESET]);
			alarm_seen_q <= alarm_now | (alarm_seen_q & filt_q[IDX_RESET]);
		end
	end

	always_comb begin
		flag_cond = main_seen_q | spare_seen_q;
		unique case (eff_set.report_mode_switch)
			fault_only_mode: flag_cond = main_seen_q | spare_seen_q;
			fault_plus_alarm_mode: flag_cond = main_seen_q | spare_seen_q | alarm_seen_q;
		endcase
	end

	// contact conducts in reset, as when unpowered
	always_ff @(posedge clock) begin
		if (srst) begin
			fault_flag_out <= 1'b0;
			isolated_fault_pos <= 1'b1;
			isolated_fault_neg <= 1'b0;
		end else begin
			fault_flag_out <= flag_cond;
			isolated_fault_pos <= flag_cond;
			isolated_fault_neg <= ~flag_cond;
		end
	end

	AST_REMOTE_DISABLE: assert property (@(posedge clock) disable iff (srst)
		panel_failover_on && !filt_q[IDX_FAILOVER] |=> !failover_active)
		else $error("failover still active with remote enable low");

	AST_REMOTE_ENABLE: assert property (@(posedge clock) disable iff (srst)
		panel_failover_on && filt_q[IDX_FAILOVER] |=> failover_active)
		else $error("failover not restored with remote enable high");

	AST_PANEL_OFF: assert property (@(posedge clock) disable iff (srst)
		!panel_failover_on ##1 !panel_failover_on |-> !failover_active)
		else $error("remote input enabled failover while panel disabled");

	AST_TOGGLE: assert property (@(posedge clock) disable iff (srst)
		toggle_fall |=> sel_q != $past(sel_q))
		else $error("toggle press did not flip source");

	AST_MAIN_IND: assert property (@(posedge clock) disable iff (srst)
		sel_q == main_input |=> main_sel_out && !spare_sel_out)
		else $error("main indicator wrong");

	AST_SPARE_IND: assert property (@(posedge clock) disable iff (srst)
		sel_q == spare_input |=> spare_sel_out && !main_sel_out)
		else $error("spare indicator wrong");

	AST_FAULT_FLAG: assert property (@(posedge clock) disable iff (srst)
		main_fault || spare_fault |-> ##2 fault_flag_out)
		else $error("input fault did not raise flag");

	AST_ALARM_FLAG: assert property (@(posedge clock) disable iff (srst)
		psu_alarm ##1 eff_set.report_mode_switch == fault_plus_alarm_mode |=> fault_flag_out)
		else $error("alarm did not raise flag in alarm mode");

	AST_HOLD: assert property (@(posedge clock) disable iff (srst)
		main_seen_q && filt_q[IDX_RESET] |=> main_seen_q)
		else $error("fault latch dropped without reset");

	AST_CLEAR: assert property (@(posedge clock) disable iff (srst)
		!filt_q[IDX_RESET] && !main_fault && !spare_fault && !alarm_now
		|=> !main_seen_q && !spare_seen_q && !alarm_seen_q ##1 !fault_flag_out)
		else $error("error reset did not clear fault state");

	AST_CONTACT: assert property (@(posedge clock)
		srst || flag_cond |=> isolated_fault_pos && !isolated_fault_neg)
		else $error("isolated contact open during fault or reset");

	AST_CONTACT_PAIR: assert property (@(posedge clock) disable iff (srst)
		isolated_fault_pos != isolated_fault_neg)
		else $error("isolated contact pins not complementary");

	AST_ALARM_MASK: assert property (@(posedge clock) disable iff (srst)
		!alarm_seen_q && !eff_set.out_alarm_en && !psu_alarm |=> !alarm_seen_q)
		else $error("channel alarm counted while indication off");

	AST_NET_LOCAL: assert property (@(posedge clock) disable iff (srst)
		!control_remote |=> $stable(remote_set_q))
		else $error("network write took effect under local control");

	AST_NET_WRITE: assert property (@(posedge clock) disable iff (srst)
		control_remote && net_wr |=> remote_set_q == $past(net_set))
		else $error("network write lost under remote control");

	AST_RESTORE: assert property (@(posedge clock) disable iff (srst)
		!control_remote ##1 control_remote |-> eff_set == $past(remote_set_q))
		else $error("remote settings not restored");

	AST_AUTO: assert property (@(posedge clock) disable iff (srst)
		failover_active && sel_q == main_input && main_fault && !spare_fault
		|=> sel_q == spare_input)
		else $error("failover did not leave faulty source");

	AST_AUTO_SPARE: assert property (@(posedge clock) disable iff (srst)
		failover_active && sel_q == spare_input && spare_fault && !main_fault
		|=> sel_q == main_input)
		else $error("failover did not leave faulty spare source");

	AST_ONE_EDGE: assert property (@(posedge clock) disable iff (srst)
		toggle_fall |=> !toggle_fall [*2])
		else $error("held toggle produced more than one edge");

	AST_IDLE_HIGH: assert property (@(posedge clock)
		srst |=> filt_q == NUM_REMOTE'(REMOTE_IDLE) && !toggle_fall)
		else $error("remote inputs not idle after reset");

endmodule : changeover_remote_port

`default_nettype wire

// ### bench/remote_switches.sv
`timescale 1ns/1ps
`default_nettype none

module remote_switches
	import changeover_pkg::*;
(
	input wire logic toggle_closed,
	input wire logic reset_closed,
	input wire logic disable_closed,
	output remote_in_t remote_in
);
	assign remote_in = '{reset_n: !reset_closed, source_toggle_n: !toggle_closed,
		failover_enable_n: !disable_closed};
endmodule : remote_switches

`default_nettype wire

// ### bench/test_changeover_remote_port.sv
`timescale 1ns/1ps
`default_nettype none

module test_changeover_remote_port;
	import changeover_pkg::*;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic tog = 1'b0, rst = 1'b0, dis = 1'b0;
	remote_in_t remote_in;
	logic panel_on = 1'b1, remote = 1'b0, net_wr = 1'b0;
	settings_t local_set = '{report_mode_switch: fault_only_mode, out_alarm_en: 1'b1};
	settings_t net_set = NET_SET_RESET;
	logic main_fault = 1'b0, spare_fault = 1'b0, psu_alarm = 1'b0;
	logic [NUM_OUT_CH-1:0] chan_alarm = '0;
	logic main_sel, spare_sel, flag, pos, neg, fo_active;
	logic [4:0] outs;
	int fail_count = 0;
	int n_compared = 0;
	assign outs = {main_sel, spare_sel, flag, pos, neg};

	initial begin
		forever #10 clock = ~clock;
	end

	remote_switches remote_switches_i (.toggle_closed(tog), .reset_closed(rst),
		.disable_closed(dis), .remote_in(remote_in));

	changeover_remote_port changeover_remote_port_i (.clock(clock), .srst(srst),
		.remote_in(remote_in), .panel_failover_on(panel_on), .control_remote(remote),
		.local_set(local_set), .net_wr(net_wr), .net_set(net_set), .main_fault(main_fault),
		.spare_fault(spare_fault), .chan_alarm(chan_alarm), .psu_alarm(psu_alarm),
		.main_sel_out(main_sel), .spare_sel_out(spare_sel), .fault_flag_out(flag),
		.isolated_fault_pos(pos), .isolated_fault_neg(neg), .failover_active(fo_active));

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc

	task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask : chk

	// hold the reset switch past the filter time
	task automatic clear();
		rst = 1'b1;
		cyc(510);
		rst = 1'b0;
		cyc(510);
	endtask : clear

	// pulse psu_alarm (0), spare_fault (1) or main_fault (2), then wait out flag latency
	task automatic blip(input int which);
		if (which == 0) begin
			psu_alarm = 1'b1;
		end else if (which == 1) begin
			spare_fault = 1'b1;
		end else begin
			main_fault = 1'b1;
		end
		cyc(3);
		psu_alarm = 1'b0;
		spare_fault = 1'b0;
		main_fault = 1'b0;
		cyc(3);
	endtask : blip

	task automatic end_of_test();
		if (fail_count == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test

	task automatic t_reset();
		cyc(8);
		chk("outs in reset", 5'b00010, outs);
		srst = 1'b0;
		cyc(3);
		chk("outs idle", 5'b10001, outs);
		chk("failover", 5'd1, {4'd0, fo_active});
	endtask : t_reset

	task automatic t_toggle();
		tog = 1'b1;
		cyc(100);
		tog = 1'b0;
		cyc(520);
		chk("short press", 5'b10001, outs);
		tog = 1'b1;
		cyc(520);
		chk("press", 5'b01001, outs);
		cyc(1000);
		chk("held press", 5'b01001, outs);
		tog = 1'b0;
		cyc(520);
		tog = 1'b1;
		cyc(520);
		chk("second press", 5'b10001, outs);
		tog = 1'b0;
		cyc(520);
	endtask : t_toggle

	task automatic t_fault();
		main_fault = 1'b1;
		cyc(2);
		chk("fault switch", 5'b01110, outs);
		main_fault = 1'b0;
		cyc(50);
		chk("latched", 5'b01110, outs);
		clear();
		chk("cleared", 5'b01001, outs);
		main_fault = 1'b1;
		spare_fault = 1'b1;
		cyc(5);
		chk("both faulty", 5'b01110, outs);
		main_fault = 1'b0;
		spare_fault = 1'b0;
		clear();
	endtask : t_fault

	task automatic t_disable();
		dis = 1'b1;
		cyc(510);
		chk("remote disable", 5'd0, {4'd0, fo_active});
		blip(1);
		chk("no switch", 5'b01110, outs);
		dis = 1'b0;
		cyc(510);
		chk("remote enable", 5'd1, {4'd0, fo_active});
		blip(1);
		chk("auto to main", 5'b10110, outs);
		blip(2);
		chk("auto to spare", 5'b01110, outs);
		panel_on = 1'b0;
		cyc(3);
		chk("panel off", 5'd0, {4'd0, fo_active});
		panel_on = 1'b1;
		clear();
	endtask : t_disable

	task automatic t_alarm();
		blip(0);
		chk("alarm fault only", 5'b01001, outs);
		clear();
		local_set = '{report_mode_switch: fault_plus_alarm_mode, out_alarm_en: 1'b0};
		chan_alarm = 9'h1FF;
		cyc(3);
		chan_alarm = 9'h000;
		cyc(3);
		chk("chan alarm off", 5'b01001, outs);
		blip(0);
		chk("psu alarm", 5'b01110, outs);
		clear();
		local_set.out_alarm_en = 1'b1;
		chan_alarm = 9'h100;
		cyc(3);
		chan_alarm = 9'h000;
		cyc(3);
		chk("chan 11 alarm", 5'b01110, outs);
		clear();
	endtask : t_alarm

	task automatic t_network();
		local_set = '{report_mode_switch: fault_only_mode, out_alarm_en: 1'b1};
		net_set = '{report_mode_switch: fault_plus_alarm_mode, out_alarm_en: 1'b1};
		net_wr = 1'b1;
		cyc(1);
		net_wr = 1'b0;
		remote = 1'b1;
		blip(0);
		chk("write while local", 5'b01001, outs);
		net_wr = 1'b1;
		cyc(1);
		net_wr = 1'b0;
		cyc(3);
		chk("write while remote", 5'b01110, outs);
		remote = 1'b0;
		cyc(3);
		chk("back to local", 5'b01001, outs);
		remote = 1'b1;
		cyc(3);
		chk("remote restored", 5'b01110, outs);
	endtask : t_network

	// whole run is near 11000 cycles; about three times that is a hang
	initial begin
		#640us;
		fail_count++;
		end_of_test();
	end

	initial begin
		t_reset();
		t_toggle();
		t_fault();
		t_disable();
		t_alarm();
		t_network();
		end_of_test();
	end
endmodule : test_changeover_remote_port

`default_nettype wire
